// File: include/fcd_map.svh
/*
 Constants for the flash command host: register offsets, field positions,
 command codes, reset values and bus timing counts.
 Assumes a 100 MHz aclk and an AXI4-Lite master on the register side.
*/
// What this block does
// R01 - Program: AA, 55, A0, then address/data
// R02 - Device matches only A11..A0 and low byte
// R03 - Erase: six writes, 10 chip, 30 sector
// R04 - Lockdown: erase prefix, final 60 at sector
// R05 - 555/A0 after erase prefix: single-pulse mode
// R06 - B0 suspends, 30 resumes; ready high
// R07 - ID mode: 555/90; exit F0 forms
// R08 - Exit data other than F0 works; use F0
// R09 - Block B query: read 80, D1 lock state
// R10 - Protection program C0; lock writes 080/X0
// R11 - Protection words at 81..88, upper zero
// R12 - Config write D0 then 00/01; reset 00
// R13 - Busy status: poll, toggles, limit, ready low
// R14 - Erase suspended: erasing sector status pattern
// R15 - Program suspended: programming sector status pattern
// R16 - Limit bit set on overrun or protected
// R17 - Query mode: 98 at 55, exit ID exit
// R18 - Ready/busy open drain, low while busy
// R19 - Single-pulse persists; all writes are data
// R20 - Broken sequence returns device to read
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH
// Register word offsets
`define FCD_REG_CTRL 8'h00
`define FCD_REG_ADDR 8'h04
`define FCD_REG_DATA 8'h08
`define FCD_REG_STAT 8'h0c
`define FCD_REG_RDATA 8'h10
// Control fields
`define FCD_CTRL_OP_LSB 0
`define FCD_CTRL_GO_BIT 8
// Status fields
`define FCD_STAT_BUSY_BIT 0
`define FCD_STAT_RDY_BIT 1
`define FCD_STAT_POLL_BIT 2
`define FCD_STAT_TOG_BIT 3
`define FCD_STAT_LIM_BIT 4
`define FCD_STAT_TOG2_BIT 5
`define FCD_STAT_DONE_BIT 6
// Command addresses and codes
`define FCD_A_555 12'h555
`define FCD_A_2AA 12'h2aa
`define FCD_A_55 12'h055
`define FCD_A_080 12'h080
`define FCD_D_AA 8'haa
`define FCD_D_55 8'h55
`define FCD_D_A0 8'ha0
`define FCD_D_80 8'h80
`define FCD_D_10 8'h10
`define FCD_D_30 8'h30
`define FCD_D_60 8'h60
`define FCD_D_B0 8'hb0
`define FCD_D_90 8'h90
`define FCD_D_F0 8'hf0
`define FCD_D_C0 8'hc0
`define FCD_D_D0 8'hd0
`define FCD_D_98 8'h98
`define FCD_D_X0 8'h00
// Status bit positions on the flash data bus
`define FCD_IO_POLL 7
`define FCD_IO_TOG 6
`define FCD_IO_LIM 5
`define FCD_IO_TOG2 2
`define FCD_IO_LOCKB 1
// Reset value of the ops register
`define FCD_CTRL_RESET 9'h000
// Bus cycle timing, ns and cycles
`define FCD_CLK_NS 10
`define FCD_T_PULSE_NS 40
`define FCD_T_PULSE_CYC ((`FCD_T_PULSE_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`endif

// File: include/fcd_pkg.sv
/*
 Types for the flash command host: operations, state and flash pins.
 Assumes fcd_map.svh supplies the numeric constants.
*/
package fcd_pkg;
    // Operations software can start
    typedef enum logic [3:0] {
        FCD_OP_PROG = 4'h0, FCD_OP_CHIP_ERASE = 4'h1, FCD_OP_SECT_ERASE = 4'h2,
        FCD_OP_LOCKDOWN = 4'h3, FCD_OP_SPULSE_ENTER = 4'h4, FCD_OP_SINGLE = 4'h5,
        FCD_OP_SUSPEND = 4'h6, FCD_OP_RESUME = 4'h7, FCD_OP_ID_ENTER = 4'h8,
        FCD_OP_ID_EXIT3 = 4'h9, FCD_OP_ID_EXIT1 = 4'ha, FCD_OP_PROT_PROG = 4'hb,
        FCD_OP_PROT_LOCK = 4'hc, FCD_OP_CONFIG = 4'hd, FCD_OP_QUERY = 4'he,
        FCD_OP_READ = 4'hf
    } fcd_op_t;
    // Sequencer phases, one-hot
    typedef enum logic [3:0] {
        FCD_ST_IDLE = 4'b0001, FCD_ST_SETUP = 4'b0010,
        FCD_ST_PULSE = 4'b0100, FCD_ST_HOLD = 4'b1000
    } fcd_state_t;
    // Flash-side pins driven by the host
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic data_oe_n;
        logic [19:0] addr;
        logic [15:0] dout;
    } fcd_pins_t;
    // Whole module state
    typedef struct packed {
        fcd_state_t st;
        fcd_pins_t pins;
        logic [2:0] idx;
        logic [2:0] len;
        logic [7:0] cnt;
        logic is_read;
        fcd_op_t op;
        logic [19:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic done;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wbuf;
        logic bvalid;
        logic rvalid;
        logic [31:0] rd;
    } fcd_state_all_t;
endpackage : fcd_pkg

// File: design/fcd_host.sv
/*
 Host controller for a parallel NOR flash: takes operations over AXI4-Lite
 and plays the matching write-cycle sequences on the flash pins.
 Assumes flash inputs are synchronous to aclk; data bus is three signals.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fcd_map.svh"
module fcd_host #(
    parameter int PULSE_CYC = `FCD_T_PULSE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [19:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input wire logic [15:0] flash_dq_in,
    input wire logic flash_ready_in
);
    fcd_pkg::fcd_state_all_t s, next_s;

    // One step of a sequence: 12-bit command address or user address
    function automatic logic [35:0] fcd_step(input fcd_pkg::fcd_op_t op,
        input logic [2:0] i, input logic [19:0] a, input logic [15:0] d);
        logic [11:0] ca;
        logic [7:0] cd;
        logic use_user;
        logic use_sa; // User address carrying a command code
        ca = `FCD_A_555;
        cd = `FCD_D_AA;
        use_user = 1'b0;
        use_sa = 1'b0;
        // Unlock prefix shared by all multi-cycle commands [R01] [R03]
        if (i == 3'd1 || i == 3'd4) begin
            ca = `FCD_A_2AA;
            cd = `FCD_D_55;
        end else if (i == 3'd3) begin
            cd = `FCD_D_AA;
        end
        case (op)
            fcd_pkg::FCD_OP_PROG: begin
                if (i == 3'd2) cd = `FCD_D_A0; // [R01]
                if (i == 3'd3) use_user = 1'b1;
            end
            fcd_pkg::FCD_OP_CHIP_ERASE: begin
                if (i == 3'd2) cd = `FCD_D_80;
                if (i == 3'd5) cd = `FCD_D_10; // [R03]
            end
            fcd_pkg::FCD_OP_SECT_ERASE, fcd_pkg::FCD_OP_LOCKDOWN: begin
                if (i == 3'd2) cd = `FCD_D_80;
                // Sector address with 30 or 60 [R03] [R04]
                if (i == 3'd5) begin
                    use_sa = 1'b1;
                    cd = (op == fcd_pkg::FCD_OP_LOCKDOWN) ? `FCD_D_60 : `FCD_D_30;
                end
            end
            fcd_pkg::FCD_OP_SPULSE_ENTER: begin
                if (i == 3'd2) cd = `FCD_D_80;
                if (i == 3'd5) cd = `FCD_D_A0; // [R05]
            end
            fcd_pkg::FCD_OP_SINGLE: use_user = 1'b1; // [R05] [R19]
            fcd_pkg::FCD_OP_SUSPEND: cd = `FCD_D_B0; // [R06]
            fcd_pkg::FCD_OP_RESUME: cd = `FCD_D_30; // [R06]
            fcd_pkg::FCD_OP_ID_ENTER: if (i == 3'd2) cd = `FCD_D_90; // [R07]
            fcd_pkg::FCD_OP_ID_EXIT3: if (i == 3'd2) cd = `FCD_D_F0; // [R07] [R08]
            fcd_pkg::FCD_OP_ID_EXIT1: cd = `FCD_D_F0; // [R08]
            fcd_pkg::FCD_OP_PROT_PROG: begin
                if (i == 3'd2) cd = `FCD_D_C0; // [R10]
                if (i == 3'd3) use_user = 1'b1; // [R11]
            end
            fcd_pkg::FCD_OP_PROT_LOCK: begin
                if (i == 3'd2) cd = `FCD_D_C0;
                if (i == 3'd3) begin
                    ca = `FCD_A_080; // [R10]
                    cd = `FCD_D_X0;
                end
            end
            fcd_pkg::FCD_OP_CONFIG: begin
                if (i == 3'd2) cd = `FCD_D_D0; // [R12]
                if (i == 3'd3) cd = {7'h00, d[0]};
            end
            fcd_pkg::FCD_OP_QUERY: begin
                ca = `FCD_A_55; // [R17]
                cd = `FCD_D_98;
            end
            default: use_user = 1'b1;
        endcase
        if (use_user) fcd_step = {a, d};
        // Code, not user data, goes with the sector address [R03] [R04]
        else if (use_sa) fcd_step = {a, 8'h00, cd};
        else fcd_step = {8'h00, ca, 8'h00, cd}; // Upper lines zero [R02] [R11]
    endfunction : fcd_step

    // Bus cycle count of each operation
    function automatic logic [2:0] fcd_len(input fcd_pkg::fcd_op_t op);
        case (op)
            fcd_pkg::FCD_OP_CHIP_ERASE, fcd_pkg::FCD_OP_SECT_ERASE,
            fcd_pkg::FCD_OP_LOCKDOWN, fcd_pkg::FCD_OP_SPULSE_ENTER: fcd_len = 3'd6;
            fcd_pkg::FCD_OP_ID_ENTER, fcd_pkg::FCD_OP_ID_EXIT3: fcd_len = 3'd3;
            fcd_pkg::FCD_OP_PROG, fcd_pkg::FCD_OP_PROT_PROG,
            fcd_pkg::FCD_OP_PROT_LOCK, fcd_pkg::FCD_OP_CONFIG: fcd_len = 3'd4;
            default: fcd_len = 3'd1;
        endcase
    endfunction : fcd_len

    // Next-state logic: AXI slave plus pin sequencer
    always_comb begin
        logic [35:0] stp;
        logic [31:0] rv;
        next_s = s;
        stp = fcd_step(s.op, s.idx, s.addr, s.wdata);
        rv = 32'h0000_0000;
        // Capture address and data in either order
        if (s_awvalid && !s.aw_got) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_awaddr;
        end
        if (s_wvalid && !s.w_got) begin
            next_s.w_got = 1'b1;
            next_s.wbuf = s_wdata;
        end
        // Commit a write once both halves are held
        if (s.aw_got && s.w_got && !s.bvalid) begin
            next_s.bvalid = 1'b1;
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            if (s.awaddr == `FCD_REG_ADDR) next_s.addr = s.wbuf[19:0];
            if (s.awaddr == `FCD_REG_DATA) next_s.wdata = s.wbuf[15:0];
            // Start only when idle; a write while busy is dropped
            if (s.awaddr == `FCD_REG_CTRL && s.wbuf[`FCD_CTRL_GO_BIT]
                && s.st == fcd_pkg::FCD_ST_IDLE) begin
                next_s.op = fcd_pkg::fcd_op_t'(s.wbuf[3:0]);
                next_s.len = fcd_len(fcd_pkg::fcd_op_t'(s.wbuf[3:0]));
                next_s.is_read = (s.wbuf[3:0] == 4'hf);
                next_s.idx = 3'd0;
                next_s.done = 1'b0;
                next_s.cnt = 8'h00;
                next_s.st = fcd_pkg::FCD_ST_SETUP;
            end
        end
        if (s.bvalid && s_bready) next_s.bvalid = 1'b0;
        // Read path: status mixes sequencer busy/done, the ready pin and the last flash read
        case (s_araddr)
            `FCD_REG_ADDR: rv = {12'h000, s.addr};
            `FCD_REG_DATA: rv = {16'h0000, s.wdata};
            `FCD_REG_CTRL: rv = {28'h0000000, s.op};
            `FCD_REG_RDATA: rv = {16'h0000, s.rdata}; // Lock state on D1 [R09]
            `FCD_REG_STAT: begin
                rv[`FCD_STAT_BUSY_BIT] = (s.st != fcd_pkg::FCD_ST_IDLE);
                rv[`FCD_STAT_RDY_BIT] = flash_ready_in; // [R18]
                rv[`FCD_STAT_POLL_BIT] = s.rdata[`FCD_IO_POLL]; // [R13] [R14]
                rv[`FCD_STAT_TOG_BIT] = s.rdata[`FCD_IO_TOG]; // [R15]
                rv[`FCD_STAT_LIM_BIT] = s.rdata[`FCD_IO_LIM]; // [R16]
                rv[`FCD_STAT_TOG2_BIT] = s.rdata[`FCD_IO_TOG2];
                rv[`FCD_STAT_DONE_BIT] = s.done;
            end
            default: rv = 32'h0000_0000;
        endcase
        if (s_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rd = rv;
        end
        if (s.rvalid && s_rready) next_s.rvalid = 1'b0;
        // Pin sequencer: setup, strobe, hold for each bus cycle
        case (s.st)
            fcd_pkg::FCD_ST_IDLE: begin
                next_s.pins.ce_n = 1'b1;
                next_s.pins.we_n = 1'b1;
                next_s.pins.oe_n = 1'b1;
                next_s.pins.data_oe_n = 1'b1;
            end
            fcd_pkg::FCD_ST_SETUP: begin
                next_s.pins.addr = s.is_read ? s.addr : stp[35:16];
                next_s.pins.dout = stp[15:0];
                next_s.pins.ce_n = 1'b0;
                next_s.pins.data_oe_n = s.is_read; // Drive low while writing
                next_s.cnt = 8'h00;
                next_s.st = fcd_pkg::FCD_ST_PULSE;
            end
            fcd_pkg::FCD_ST_PULSE: begin
                next_s.pins.we_n = s.is_read;
                next_s.pins.oe_n = !s.is_read;
                next_s.cnt = s.cnt + 8'h01;
                if (s.cnt == 8'(PULSE_CYC)) begin
                    if (s.is_read) next_s.rdata = flash_dq_in;
                    next_s.pins.we_n = 1'b1;
                    next_s.pins.oe_n = 1'b1;
                    next_s.st = fcd_pkg::FCD_ST_HOLD;
                end
            end
            fcd_pkg::FCD_ST_HOLD: begin
                next_s.pins.ce_n = 1'b1;
                next_s.pins.data_oe_n = 1'b1;
                if (s.idx + 3'd1 >= s.len) begin
                    next_s.done = 1'b1;
                    next_s.st = fcd_pkg::FCD_ST_IDLE;
                end else begin
                    next_s.idx = s.idx + 3'd1;
                    next_s.st = fcd_pkg::FCD_ST_SETUP;
                end
            end
            default: next_s.st = fcd_pkg::FCD_ST_IDLE;
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.st <= fcd_pkg::FCD_ST_IDLE;
            s.pins.ce_n <= 1'b1;
            s.pins.oe_n <= 1'b1;
            s.pins.we_n <= 1'b1;
            s.pins.data_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Port drive
    assign s_awready = !s.aw_got;
    assign s_wready = !s.w_got;
    assign s_bvalid = s.bvalid;
    assign s_bresp = 2'b00;
    assign s_arready = !s.rvalid;
    assign s_rvalid = s.rvalid;
    assign s_rdata = s.rd;
    assign s_rresp = 2'b00;
    assign flash_ce_n = s.pins.ce_n;
    assign flash_oe_n = s.pins.oe_n;
    assign flash_we_n = s.pins.we_n;
    assign flash_addr = s.pins.addr;
    assign flash_dq_out = s.pins.dout;
    assign flash_dq_oe_n = s.pins.data_oe_n;

    // Every first cycle of a multi-cycle operation starts at 555 with AA
    fcd_first_aa_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
        (s.st == fcd_pkg::FCD_ST_SETUP && s.idx == 3'd0 && s.len > 3'd1)
        |=> (flash_addr[11:0] == 12'h555 && flash_dq_out[7:0] == 8'haa))
        else $error("first unlock cycle wrong");
    // Write strobe never overlaps output enable
    fcd_we_oe_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
        !(!flash_we_n && !flash_oe_n)) else $error("we and oe both low");
    // Data driven during a write strobe
    fcd_drive_we_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
        !flash_we_n |-> !flash_dq_oe_n) else $error("undriven write");
    // Write pulse lasts the set number of cycles
    fcd_pulse_len_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
        $fell(flash_we_n) |-> !flash_we_n [*4]) else $error("short write pulse");
    // Protection lock fourth cycle at 080 with 00, upper address zero
    fcd_upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        (s.st == fcd_pkg::FCD_ST_SETUP && s.op == fcd_pkg::FCD_OP_PROT_LOCK
        && s.idx == 3'd3) |=> (flash_addr == 20'h00080 && flash_dq_out[7:0] == 8'h00))
        else $error("lock cycle wrong");
    // Config fourth cycle carries 00 or 01
    fcd_cfg_val_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        (s.st == fcd_pkg::FCD_ST_SETUP && s.op == fcd_pkg::FCD_OP_CONFIG
        && s.idx == 3'd3) |=> (flash_dq_out[7:1] == 7'h00))
        else $error("config value out of range");
    // Busy op ends within a bounded time
    fcd_done_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
        $rose(s.st == fcd_pkg::FCD_ST_SETUP) && s.idx == 3'd0
        |-> ##[1:60] s.st == fcd_pkg::FCD_ST_IDLE) else $error("sequence hung");
    // Write response follows a taken write
    fcd_bresp_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
        (s.aw_got && s.w_got && !s.bvalid) |=> s_bvalid) else $error("no bresp");
endmodule : fcd_host
`default_nettype wire

// File: dv/fcd_flash_model.sv
/*
 Behavioural flash device: decodes host write cycles into commands,
 holds busy time, ID mode, config and block B lock, answers reads.
 Assumes the host pins change only on aclk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module fcd_flash_model #(
    parameter int BUSY_CYC = 200
) (
    input wire logic aclk,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [19:0] addr,
    input wire logic [15:0] dq_from_host,
    output logic [15:0] dq_to_host,
    output logic ready,
    output logic [7:0] last_cmd,
    output logic [19:0] last_a,
    output logic [7:0] cfg,
    output logic id_mode
);
    logic p_we = 1'b1; // Write strobe one edge ago
    logic [2:0] step = 3'h0; // Position inside an unlock sequence
    logic [7:0] kind = 8'h0; // Third-cycle code awaiting its data cycle
    logic [11:0] wa = 12'h0; // Latched low address of the write
    logic [7:0] wd = 8'h0; // Latched low data byte of the write
    logic [19:0] fa = 20'h0; // Full address, kept for the bench
    logic [7:0] pd = 8'h0; // Byte being programmed
    logic tog = 1'b0; // Free-running toggle source
    logic susp = 1'b0; // Operation suspended
    logic er = 1'b0; // Busy with an erase rather than a program
    logic lockb = 1'b1; // Block B still reprogrammable
    logic spulse = 1'b0; // Single-pulse mode, left only by power-up
    logic [15:0] q = 16'h0; // Last value put on the bus
    int cnt = 0; // Remaining busy cycles
    wire wr = !p_we && we_n; // Rising write strobe ends a cycle
    initial begin
        last_cmd = 8'h0;
        last_a = 20'h0;
        cfg = 8'h00;
        id_mode = 1'b0;
    end
    // Released bus shows the inverse of the last value, never a held copy
    always_comb begin
        if (!ce_n && !oe_n && cnt != 0 && susp)
            dq_to_host = {8'h0, 3'b110, 2'b0, tog, 2'b0};
        else if (!ce_n && !oe_n && cnt != 0)
            // Limit bit stays 0: operations never overrun here
            dq_to_host = {8'h0, !er && !cfg[0] && !pd[7], tog, 3'b0,
                er ? tog : 1'b1, 2'b0};
        else if (!ce_n && !oe_n && id_mode && addr[7:0] == 8'h80)
            dq_to_host = {14'h0, lockb, 1'b0};
        else if (!ce_n && !oe_n)
            dq_to_host = addr[15:0];
        else
            dq_to_host = ~q;
    end
    assign ready = cnt == 0 || susp; // Open drain with pull-up, resolved
    // Command decode compares only A11..A0 and the low byte
    always @(posedge aclk) begin
        p_we <= we_n;
        tog <= ~tog;
        q <= dq_to_host;
        if (!we_n && !ce_n) begin
            wa <= addr[11:0];
            wd <= dq_from_host[7:0];
            fa <= addr;
        end
        if (cnt != 0 && !susp)
            cnt <= cnt - 1;
        if (wr && spulse) begin
            last_cmd <= 8'ha0; // Every write is program data
            last_a <= fa;
            cnt <= BUSY_CYC;
        end else if (wr) begin
            step <= 3'h0; // A broken sequence falls back to read
            case (step)
                3'h0: begin
                    if (wa == 12'h555 && wd == 8'haa) begin
                        step <= 3'h1;
                    end else begin
                        last_cmd <= wd;
                        last_a <= fa;
                        if (wd == 8'hb0) susp <= 1'b1;
                        else if (wd == 8'h30) susp <= 1'b0;
                        else if (wd == 8'h98 && wa == 12'h055) id_mode <= 1'b1;
                        else id_mode <= 1'b0; // Any exit byte works
                    end
                end
                3'h1, 3'h5: begin
                    if ((wa == 12'h2aa || wa == 12'haaa) && wd == 8'h55)
                        step <= step + 3'h1;
                end
                3'h2: begin
                    kind <= wd;
                    if (wa == 12'h555 && (wd == 8'ha0 || wd == 8'hc0 || wd == 8'hd0))
                        step <= 3'h3;
                    if (wa == 12'h555 && wd == 8'h80) step <= 3'h4;
                    if (wa == 12'h555 && (wd == 8'h90 || wd == 8'hf0)) begin
                        id_mode <= wd == 8'h90;
                        last_cmd <= wd;
                    end
                end
                3'h3: begin
                    last_cmd <= kind;
                    last_a <= fa;
                    if (kind == 8'ha0) begin
                        cnt <= BUSY_CYC;
                        er <= 1'b0;
                        pd <= wd;
                    end
                    if (kind == 8'hd0) cfg <= wd;
                    if (kind == 8'hc0 && wa == 12'h080) lockb <= 1'b0;
                end
                3'h4: if (wa == 12'h555 && wd == 8'haa) step <= 3'h5;
                default: begin
                    last_cmd <= wd; // 60 lockdown only noted; A0 at 555 enters single-pulse mode
                    last_a <= fa;
                    if (wd == 8'ha0 && wa == 12'h555) spulse <= 1'b1;
                    if (wd == 8'h10 || wd == 8'h30) begin
                        cnt <= BUSY_CYC;
                        er <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule : fcd_flash_model
`default_nettype wire

// File: dv/fcd_host_tb.sv
/*
 Self-checking bench for the flash command host: drives AXI4-Lite,
 the flash model answers on the far side.
 Assumes fcd_map.svh and fcd_pkg are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fcd_map.svh"
module fcd_host_tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, doe_n, frdy, idm;
    logic [7:0] awaddr, araddr, lcmd, cfg;
    logic [31:0] wdata, rdata, s;
    logic [1:0] bresp, rresp;
    logic [19:0] fa, la;
    logic [15:0] fdo, fdi;
    int failures = 0; // Mismatches seen
    int checks_done = 0; // Comparisons made
    fcd_host #(.PULSE_CYC(4)) fcd_host_inst (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
        .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
        .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(rready), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_addr(fa), .flash_dq_out(fdo), .flash_dq_oe_n(doe_n), .flash_dq_in(fdi),
        .flash_ready_in(frdy));
    fcd_flash_model fcd_flash_model_inst (.aclk(aclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(fa), .dq_from_host(fdo), .dq_to_host(fdi), .ready(frdy), .last_cmd(lcmd),
        .last_a(la), .cfg(cfg), .id_mode(idm));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Closing verdict, shared with the watchdog
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Handshakes judged at the falling edge, acted on at the next rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(negedge aclk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end while (!b);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic ar, r;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(negedge aclk);
            ar = arvalid && arready;
            r = rvalid && rready;
            d = rdata;
            @(posedge aclk);
            if (ar) arvalid <= 1'b0;
            if (r) rready <= 1'b0;
        end while (!r);
    endtask : rd
    // Start one operation and wait for its done flag
    task automatic op(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d);
        logic [31:0] t;
        wr(`FCD_REG_ADDR, {12'h0, a});
        wr(`FCD_REG_DATA, {16'h0, d});
        wr(`FCD_REG_CTRL, {23'h0, 1'b1, 4'h0, o});
        t = 32'h0;
        while (t[`FCD_STAT_DONE_BIT] !== 1'b1) rd(`FCD_REG_STAT, t);
    endtask : op
    task automatic rd_flash(input logic [19:0] a);
        op(fcd_pkg::FCD_OP_READ, a, 16'h0);
        rd(`FCD_REG_RDATA, s);
    endtask : rd_flash
    task automatic wait_rdy;
        s = 32'h0;
        while (s[`FCD_STAT_RDY_BIT] !== 1'b1) rd(`FCD_REG_STAT, s);
    endtask : wait_rdy
    task automatic t_prog;
        op(fcd_pkg::FCD_OP_PROG, 20'hf4321, 16'hab5c);
        chk({lcmd, 4'h0, la}, {8'ha0, 24'hf4321});
        rd_flash(20'hf4321);
        chk(s & 32'ha0, 32'h80); // Inverted bit 7, limit clear
        rd(`FCD_REG_STAT, s);
        chk(s & 32'h3, 32'h0);
        wait_rdy();
    endtask : t_prog
    task automatic t_erase;
        op(fcd_pkg::FCD_OP_SECT_ERASE, 20'h40010, 16'h0);
        chk({lcmd, 4'h0, la}, {8'h30, 24'h40010});
        op(fcd_pkg::FCD_OP_SUSPEND, 20'h0, 16'h0);
        rd(`FCD_REG_STAT, s);
        chk({lcmd, s[7:0] & 8'h02}, 16'hb002);
        rd_flash(20'h40010);
        chk(s & 32'he0, 32'hc0);
        op(fcd_pkg::FCD_OP_RESUME, 20'h0, 16'h0);
        rd(`FCD_REG_STAT, s);
        chk({lcmd, s[7:0] & 8'h02}, 16'h3000);
        rd_flash(20'h40010);
        chk(s & 32'ha0, 32'h0);
        wait_rdy();
        op(fcd_pkg::FCD_OP_CHIP_ERASE, 20'h0, 16'h0);
        chk({24'h0, lcmd}, 32'h10);
        wait_rdy();
    endtask : t_erase
    task automatic t_id;
        op(fcd_pkg::FCD_OP_ID_ENTER, 20'h0, 16'h0);
        chk({31'h0, idm}, 32'h1);
        rd_flash(20'h00080);
        chk(s & 32'h2, 32'h2);
        op(fcd_pkg::FCD_OP_ID_EXIT1, 20'h0, 16'h0);
        chk({lcmd, 7'h0, idm}, 16'hf000);
        op(fcd_pkg::FCD_OP_PROT_PROG, 20'h00085, 16'h1234);
        chk({lcmd, 4'h0, la}, {8'hc0, 24'h00085});
        op(fcd_pkg::FCD_OP_PROT_LOCK, 20'h0, 16'h0);
        chk({lcmd, 4'h0, la}, {8'hc0, 24'h00080});
        op(fcd_pkg::FCD_OP_ID_ENTER, 20'h0, 16'h0);
        rd_flash(20'h00080);
        chk(s & 32'h2, 32'h0);
        op(fcd_pkg::FCD_OP_ID_EXIT3, 20'h0, 16'h0);
        chk({lcmd, 7'h0, idm}, 16'hf000);
    endtask : t_id
    task automatic t_misc;
        op(fcd_pkg::FCD_OP_CONFIG, 20'h0, 16'h1);
        chk({24'h0, cfg}, 32'h1);
        op(fcd_pkg::FCD_OP_PROG, 20'h00100, 16'h0000);
        rd_flash(20'h00100);
        chk(s & 32'h80, 32'h0);
        wait_rdy();
        op(fcd_pkg::FCD_OP_LOCKDOWN, 20'h08000, 16'h0);
        chk({lcmd, 4'h0, la}, {8'h60, 24'h08000});
        op(fcd_pkg::FCD_OP_QUERY, 20'h0, 16'h0);
        chk({lcmd, la[11:0]}, {8'h98, 12'h055});
        op(fcd_pkg::FCD_OP_SPULSE_ENTER, 20'h0, 16'h0);
        op(fcd_pkg::FCD_OP_SINGLE, 20'h12345, 16'h00b0); // Suspend code taken as data
        chk({lcmd, 4'h0, la}, {8'ha0, 24'h12345});
    endtask : t_misc
    // Watchdog sized well above the expected run of about 1.5k cycles
    initial begin
        repeat (80000) @(posedge aclk);
        failures++;
        complete_run();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`FCD_REG_STAT, s);
        chk(s & 32'h43, 32'h2);
        chk({24'h0, cfg}, 32'h0);
        t_prog();
        t_erase();
        t_id();
        t_misc();
        complete_run();
    end
endmodule : fcd_host_tb
`default_nettype wire
